//--- design/scm_master.v
// Purpose: two-wire serial bus master running whole transfers on its own
// Assumes: sole master on the bus, slaves never stretch the clock
// Notes: lines are open drain; output enables pull low, release lets pull-ups win
`timescale 1ns/100ps
`include "scm_defines.vh"

module scm_master
(
  // clock, reset, enable
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_clk_en,
  // transfer command
  input wire i_start,
  input wire [1:0] i_rate,
  input wire [1:0] i_type,
  input wire [6:0] i_addr,
  input wire [`SCM_LEN_W-1:0] i_wr_len,
  input wire [`SCM_LEN_W-1:0] i_rd_len,
  // send buffer load
  input wire i_tx_we,
  input wire [`SCM_IDX_W-1:0] i_tx_idx,
  input wire [`SCM_DATA_W-1:0] i_tx_data,
  // receive buffer readback
  input wire [`SCM_IDX_W-1:0] i_rx_idx,
  output wire [`SCM_DATA_W-1:0] o_rx_data,
  // status
  output wire o_busy,
  output wire o_done,
  output wire o_nack,
  // bus lines
  output wire o_scl_o,
  output wire o_scl_oe,
  input wire i_sda,
  output wire o_sda_o,
  output wire o_sda_oe
);

  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BYTE = 2'h2;
  localparam ST_STOP = 2'h3;

  // quarter period lengths per rate
  localparam integer QTR_100K = `SCM_QTR_100K;
  localparam integer QTR_400K = `SCM_QTR_400K;
  localparam integer QTR_800K = `SCM_QTR_800K;
  localparam integer QTR_1M = `SCM_QTR_1M;

  reg [1:0] state_r;
  reg [1:0] qph_r;
  reg [7:0] qcnt_r;
  reg [7:0] qlim_r;
  reg [3:0] bit_r;
  reg [`SCM_DATA_W-1:0] sh_r;
  reg samp_r;
  reg ackbad_r;
  reg txmode_r;
  reg isaddr_r;
  reg rdph_r;
  reg second_r;
  reg [`SCM_LEN_W-1:0] cnt_r;
  reg [`SCM_LEN_W-1:0] len_r;
  reg [`SCM_LEN_W-1:0] len2_r;
  reg [6:0] addr_r;
  reg scl_oe_r;
  reg sda_oe_r;
  reg scl_oe_nxt;
  reg sda_oe_nxt;
  reg nack_r;
  reg done_r;
  reg sda_m_r;
  reg sda_s_r;
  reg rx_we_r;
  reg [7:0] qsel;
  wire tick;
  wire last_qtr;
  wire [`SCM_LEN_W-1:0] cnt_inc;
  wire more_bytes;
  wire [`SCM_DATA_W-1:0] tx_q;
  wire first_rd;
  wire combined;
  wire [`SCM_LEN_W-1:0] wr_len_c;
  wire [`SCM_LEN_W-1:0] rd_len_c;

  // clamp a requested length into 1..16
  function [`SCM_LEN_W-1:0] clamp_len;
    input [`SCM_LEN_W-1:0] len;
    begin
      if (len == 5'h00)
        clamp_len = 5'h01;
      else if (len > `SCM_MAX_LEN)
        clamp_len = `SCM_MAX_LEN;
      else
        clamp_len = len;
    end
  endfunction

  // send bytes loaded by the processor, read by the engine
  scm_buf u_tx_buf
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_we(i_tx_we),
    .i_waddr(i_tx_idx),
    .i_wdata(i_tx_data),
    .i_raddr(cnt_r[`SCM_IDX_W-1:0]),
    .o_rdata(tx_q)
  );

  // received bytes written by the engine, read by the processor
  scm_buf u_rx_buf
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_we(rx_we_r),
    .i_waddr(cnt_r[`SCM_IDX_W-1:0]),
    .i_wdata(sh_r),
    .i_raddr(i_rx_idx),
    .o_rdata(o_rx_data)
  );

  // rate decode; 800 kHz is nonstandard, 1 MHz is best effort only
  always @*
  begin
    case (i_rate)
      `SCM_RATE_100K: qsel = QTR_100K[7:0];
      `SCM_RATE_400K: qsel = QTR_400K[7:0];
      `SCM_RATE_800K: qsel = QTR_800K[7:0];
      `SCM_RATE_1M: qsel = QTR_1M[7:0];
      default: qsel = QTR_100K[7:0];
    endcase
  end

  // command decode
  assign first_rd = (i_type == `SCM_TYPE_RD) || (i_type == `SCM_TYPE_RD_WR);
  assign combined = (i_type == `SCM_TYPE_RD_WR) || (i_type == `SCM_TYPE_WR_RD);
  assign wr_len_c = clamp_len(i_wr_len);
  assign rd_len_c = clamp_len(i_rd_len);

  // quarter-period timing
  assign tick = (state_r != ST_IDLE) && (qcnt_r == qlim_r - 8'h01);
  assign last_qtr = tick && (qph_r == `SCM_LAST_QTR);
  assign cnt_inc = cnt_r + 5'h01;
  assign more_bytes = cnt_inc < len_r;

  // data line synchroniser
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
    end
    else if (i_clk_en)
    begin
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
    end
  end

  // line levels for the current state and quarter; quarter 0 holds data while the clock falls
  always @*
  begin
    scl_oe_nxt = 1'h0;
    sda_oe_nxt = 1'h0;
    case (state_r)
      ST_IDLE:
      begin
        scl_oe_nxt = 1'h0;
        sda_oe_nxt = 1'h0;
      end
      ST_START:
      begin
        scl_oe_nxt = (qph_r < 2'h2);
        if (qph_r == `SCM_HOLD_QTR)
          sda_oe_nxt = sda_oe_r;
        else
          sda_oe_nxt = (qph_r == `SCM_LAST_QTR);
      end
      ST_BYTE:
      begin
        scl_oe_nxt = (qph_r < 2'h2);
        if (qph_r == `SCM_HOLD_QTR)
          sda_oe_nxt = sda_oe_r;
        else if (bit_r != `SCM_ACK_BIT)
          sda_oe_nxt = txmode_r && !sh_r[7];
        else
          sda_oe_nxt = !txmode_r && more_bytes;
      end
      ST_STOP:
      begin
        scl_oe_nxt = (qph_r < 2'h2);
        if (qph_r == `SCM_HOLD_QTR)
          sda_oe_nxt = sda_oe_r;
        else
          sda_oe_nxt = (qph_r != `SCM_LAST_QTR);
      end
      default:
      begin
        scl_oe_nxt = 1'h0;
        sda_oe_nxt = 1'h0;
      end
    endcase
  end

  // open-drain drivers: only ever pull low
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_oe_r <= 1'h0;
      sda_oe_r <= 1'h0;
    end
    else if (i_clk_en)
    begin
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // transfer sequencer
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      qph_r <= 2'h0;
      qcnt_r <= 8'h00;
      qlim_r <= 8'h01;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      samp_r <= 1'h1;
      ackbad_r <= 1'h0;
      txmode_r <= 1'h1;
      isaddr_r <= 1'h0;
      rdph_r <= 1'h0;
      second_r <= 1'h0;
      cnt_r <= 5'h00;
      len_r <= 5'h01;
      len2_r <= 5'h01;
      addr_r <= 7'h00;
      nack_r <= 1'h0;
      done_r <= 1'h0;
      rx_we_r <= 1'h0;
    end
    else if (i_clk_en)
    begin
      done_r <= 1'h0;
      rx_we_r <= 1'h0;
      // quarter counter runs only during a transfer
      if (state_r == ST_IDLE || tick)
        qcnt_r <= 8'h00;
      else
        qcnt_r <= qcnt_r + 8'h01;
      if (tick)
        qph_r <= qph_r + 2'h1;
      case (state_r)
        ST_IDLE:
        begin
          qph_r <= 2'h0;
          if (i_start)
          begin
            qlim_r <= qsel;
            addr_r <= i_addr;
            rdph_r <= first_rd;
            second_r <= combined;
            len_r <= first_rd ? rd_len_c : wr_len_c;
            len2_r <= first_rd ? wr_len_c : rd_len_c;
            nack_r <= 1'h0;
            state_r <= ST_START;
          end
        end
        ST_START:
        begin
          if (last_qtr)
          begin
            sh_r <= {addr_r, rdph_r};
            txmode_r <= 1'h1;
            isaddr_r <= 1'h1;
            cnt_r <= 5'h00;
            bit_r <= 4'h0;
            state_r <= ST_BYTE;
          end
        end
        ST_BYTE:
        begin
          // fetch the next data byte while the clock is low
          if (tick && qph_r == `SCM_HOLD_QTR && bit_r == 4'h0 && txmode_r && !isaddr_r)
            sh_r <= tx_q;
          // sample the data line in the middle of the high time
          if (tick && qph_r == `SCM_SAMPLE_QTR)
          begin
            if (bit_r == `SCM_ACK_BIT)
            begin
              ackbad_r <= sda_s_r;
              // store a received byte while the index still points at it
              rx_we_r <= !txmode_r && !isaddr_r;
            end
            else
              samp_r <= sda_s_r;
          end
          if (last_qtr && bit_r != `SCM_ACK_BIT)
          begin
            sh_r <= {sh_r[6:0], samp_r};
            bit_r <= bit_r + 4'h1;
          end
          else if (last_qtr)
          begin
            bit_r <= 4'h0;
            if (isaddr_r)
            begin
              isaddr_r <= 1'h0;
              txmode_r <= !rdph_r;
              if (ackbad_r)
              begin
                nack_r <= 1'h1;
                state_r <= ST_STOP;
              end
            end
            else
            begin
              if (txmode_r && ackbad_r)
              begin
                nack_r <= 1'h1;
                state_r <= ST_STOP;
              end
              else if (more_bytes)
                cnt_r <= cnt_inc;
              else if (second_r)
              begin
                // second phase: repeated start, same address with direction flipped, own length
                second_r <= 1'h0;
                rdph_r <= !rdph_r;
                len_r <= len2_r;
                state_r <= ST_START;
              end
              else
                state_r <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          // no arbitration: the stop always completes the transfer
          if (last_qtr)
          begin
            done_r <= 1'h1;
            state_r <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // outputs
  assign o_busy = (state_r != ST_IDLE);
  assign o_done = done_r;
  assign o_nack = nack_r;
  assign o_scl_o = 1'h0;
  assign o_sda_o = 1'h0;
  assign o_scl_oe = scl_oe_r;
  assign o_sda_oe = sda_oe_r;

endmodule // scm_master

//--- common/scm_defines.vh
// Purpose: shared constants of the serial control master
// Assumes: system clock of 25 MHz
// Notes: quarter periods round down so the bus can run faster than chosen, never slower
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH

// clock and bus rates in hertz
`define SCM_CLK_HZ 25000000
`define SCM_RATE_100K_HZ 100000
`define SCM_RATE_400K_HZ 400000
`define SCM_RATE_800K_HZ 800000
`define SCM_RATE_1M_HZ 1000000
`define SCM_QTR_PER_BIT 4

// cycles per quarter of a bus clock period
`define SCM_QTR_100K (`SCM_CLK_HZ / (`SCM_QTR_PER_BIT * `SCM_RATE_100K_HZ))
`define SCM_QTR_400K (`SCM_CLK_HZ / (`SCM_QTR_PER_BIT * `SCM_RATE_400K_HZ))
`define SCM_QTR_800K (`SCM_CLK_HZ / (`SCM_QTR_PER_BIT * `SCM_RATE_800K_HZ))
`define SCM_QTR_1M (`SCM_CLK_HZ / (`SCM_QTR_PER_BIT * `SCM_RATE_1M_HZ))

// rate select codes
`define SCM_RATE_100K 2'h0
`define SCM_RATE_400K 2'h1
`define SCM_RATE_800K 2'h2
`define SCM_RATE_1M 2'h3

// transfer type codes
`define SCM_TYPE_RD 2'h0
`define SCM_TYPE_WR 2'h1
`define SCM_TYPE_RD_WR 2'h2
`define SCM_TYPE_WR_RD 2'h3

// buffer geometry and byte framing
`define SCM_DATA_W 8
`define SCM_IDX_W 4
`define SCM_LEN_W 5
`define SCM_MAX_LEN 5'h10
`define SCM_ACK_BIT 4'h8
`define SCM_LAST_QTR 2'h3
`define SCM_SAMPLE_QTR 2'h2
`define SCM_HOLD_QTR 2'h0

`endif

//--- design/scm_buf.v
// Purpose: 16 x 8 byte store with one write port and one registered read port
// Assumes: both ports on the system clock
// Notes: read data appear one cycle after the address
`timescale 1ns/100ps
`include "scm_defines.vh"

module scm_buf
(
  // clock, reset, enable
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_clk_en,
  // write port
  input wire i_we,
  input wire [`SCM_IDX_W-1:0] i_waddr,
  input wire [`SCM_DATA_W-1:0] i_wdata,
  // read port
  input wire [`SCM_IDX_W-1:0] i_raddr,
  output wire [`SCM_DATA_W-1:0] o_rdata
);

  reg [`SCM_DATA_W-1:0] mem_r [0:(1<<`SCM_IDX_W)-1];
  reg [`SCM_DATA_W-1:0] rdata_r;

  // storage writes, no reset needed
  always @(posedge i_ref_clk)
  begin
    if (i_clk_en && i_we)
      mem_r[i_waddr] <= i_wdata;
  end

  // registered read
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_r <= 8'h00;
    else if (i_clk_en)
      rdata_r <= mem_r[i_raddr];
  end

  assign o_rdata = rdata_r;

endmodule // scm_buf

//--- verif/scm_checker.sv
// Purpose: port protocol checks for the serial control master
// Assumes: 25 MHz clock, async active-high reset
// Notes: bound to the master's top module
`timescale 1ns/100ps

module scm_checker
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // command and status
  input wire i_clk_en,
  input wire i_start,
  input wire [1:0] i_rate,
  input wire o_busy,
  input wire o_done,
  input wire o_nack,
  // bus lines
  input wire o_scl_o,
  input wire o_scl_oe,
  input wire o_sda_o,
  input wire o_sda_oe
);
  logic [7:0] q_r;
  logic [8:0] hi_r;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_accept;
    !o_busy && !o_done && i_start && i_clk_en;
  endsequence
  sequence s_hi_rise;
    $rose(o_scl_oe) && hi_r > 9'h003;
  endsequence
  // latch the quarter length on a start, count released clock cycles
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
    begin
      q_r <= 8'h00;
      hi_r <= 9'h000;
    end
    else
    begin
      if (!o_busy && !o_done && i_start && i_clk_en)
        q_r <= (i_rate == 2'h0) ? 8'h3E : (i_rate == 2'h1) ? 8'h0F : (i_rate == 2'h2) ? 8'h07 : 8'h06;
      hi_r <= (o_scl_oe || !o_busy) ? 9'h000 : hi_r + 9'h001;
    end
  a_scl_low_only: assert property (o_scl_o == 1'b0)
    else $error("clock line driven high");
  a_sda_low_only: assert property (o_sda_o == 1'b0)
    else $error("data line driven high");
  a_idle_release: assert property (!o_busy |-> !o_scl_oe && !o_sda_oe)
    else $error("line pulled while idle");
  a_done_one_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (o_done |-> ##[0:1] !o_busy)
    else $error("busy after done");
  a_start_clears_nack: assert property (s_accept |=> o_busy && !o_nack)
    else $error("start not taken cleanly");
  a_busy_holds_on: assert property (s_accept |=> o_busy [*8])
    else $error("busy dropped early");
  a_lines_apart: assert property ($changed(o_sda_oe) |-> $stable(o_scl_oe))
    else $error("both lines moved together");
  a_scl_high_time: assert property (s_hi_rise |-> hi_r == {q_r, 1'b0})
    else $error("clock high time off rate");
endmodule // scm_checker

bind scm_master scm_checker i_scm_checker(.i_ref_clk, .i_rst, .i_clk_en, .i_start, .i_rate, .o_busy,
  .o_done, .o_nack, .o_scl_o, .o_scl_oe, .o_sda_o, .o_sda_oe);

//--- verif/scm_slave_model.sv
// Purpose: behavioural two-wire slave for the master bench
// Assumes: one master, no stretching; pull-ups on both lines
// Notes: read bytes are 8'hA5 xor index; written bytes are logged
`timescale 1ns/100ps

module scm_slave_model
#(
  parameter logic [6:0] ADDR = 7'h50
)
(
  // bus lines
  input wire i_scl,
  input wire i_sda,
  // fault control
  input wire i_nack_data,
  // open-drain pull
  output logic o_low
);
  logic [7:0] sh_r = 8'h00;
  logic [7:0] rb_r = 8'h00;
  logic [7:0] wr_mem [16];
  logic [3:0] bit_r = 4'h0;
  logic sel_r = 1'b0;
  logic rw_r = 1'b0;
  logic dat_r = 1'b0;
  logic mack_r = 1'b1;
  int n_wr = 0;
  int rd_r = 0;
  initial o_low = 1'b0;
  // start or stop restarts framing; clock never held low
  always @(negedge i_sda or posedge i_sda)
    if (i_scl === 1'b1)
    begin
      bit_r = 4'h0;
      dat_r = 1'b0;
      sel_r = 1'b0;
      rd_r = 0;
      o_low = 1'b0;
    end
  // capture bits msb first and the acknowledge bit
  always @(posedge i_scl)
  begin
    if (bit_r < 4'h8)
      sh_r = {sh_r[6:0], i_sda};
    else
      mack_r = i_sda;
    bit_r = bit_r + 4'h1;
  end
  // acknowledge and read data change only while the clock is low
  always @(negedge i_scl)
    if (bit_r == 4'h8)
    begin
      if (!dat_r)
      begin
        sel_r = (sh_r[7:1] == ADDR);
        rw_r = sh_r[0];
      end
      else if (sel_r && !rw_r)
      begin
        wr_mem[n_wr[3:0]] = sh_r;
        n_wr++;
      end
      o_low = sel_r && !(dat_r && (rw_r || i_nack_data));
    end
    else if (bit_r == 4'h9)
    begin
      bit_r = 4'h0;
      dat_r = 1'b1;
      rb_r = 8'hA5 ^ 8'(rd_r);
      rd_r++;
      o_low = sel_r && rw_r && !mack_r && !rb_r[7];
    end
    else if (dat_r && sel_r && rw_r && !mack_r)
    begin
      rb_r = rb_r << 1;
      o_low = !rb_r[7];
    end
endmodule // scm_slave_model

//--- verif/testbench.sv
// Purpose: self-checking bench for the serial control master
// Assumes: one slave model at 7'h50 behind pull-ups
// Notes: transfer lengths are judged from the quarter counts
`timescale 1ns/100ps
`include "scm_defines.vh"

module testbench;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_start = 1'b0;
  logic [1:0] i_rate = 2'h0;
  logic [1:0] i_type = 2'h0;
  logic [6:0] i_addr = 7'h50;
  logic [4:0] i_wr_len = 5'h01;
  logic [4:0] i_rd_len = 5'h01;
  logic i_tx_we = 1'b0;
  logic [3:0] i_tx_idx = 4'h0;
  logic [7:0] i_tx_data = 8'h00;
  logic [3:0] i_rx_idx = 4'h0;
  logic nack_data = 1'b0;
  wire [7:0] o_rx_data;
  wire o_busy, o_done, o_nack, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, slv_low;
  // open-drain lines: pull-ups win unless someone pulls low
  wire scl = ~o_scl_oe;
  wire sda = ~(o_sda_oe | slv_low);
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  scm_master i_scm_master(.i_ref_clk, .i_rst, .i_clk_en, .i_start, .i_rate, .i_type, .i_addr, .i_wr_len,
    .i_rd_len, .i_tx_we, .i_tx_idx, .i_tx_data, .i_rx_idx, .o_rx_data, .o_busy, .o_done, .o_nack,
    .o_scl_o, .o_scl_oe, .i_sda(sda), .o_sda_o, .o_sda_oe);
  scm_slave_model i_scm_slave_model(.i_scl(scl), .i_sda(sda), .i_nack_data(nack_data), .o_low(slv_low));
  // clock and hang guard
  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic load(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(negedge i_ref_clk);
      i_tx_we = 1'b1;
      i_tx_idx = 4'(k);
      i_tx_data = 8'h3C ^ 8'(k);
    end
    @(negedge i_ref_clk);
    i_tx_we = 1'b0;
  endtask
  task automatic chk_rx(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(negedge i_ref_clk);
      i_rx_idx = 4'(k);
      @(negedge i_ref_clk);
      cmp(16'(o_rx_data), 16'(8'hA5 ^ 8'(k)));
    end
  endtask
  task automatic chk_wr(input int n);
    cmp(16'(i_scm_slave_model.n_wr), 16'(n));
    for (int k = 0; k < n; k++)
      cmp(16'(i_scm_slave_model.wr_mem[k]), 16'(8'h3C ^ 8'(k)));
  endtask
  // one transfer; nb counts bytes on the bus including address bytes
  task automatic xfer(input logic [1:0] rt, input logic [1:0] ty, input logic [4:0] wl, input logic [4:0] rl,
    input logic [6:0] ad, input int nb, input logic nk);
    int n;
    int e;
    n = 0;
    e = ((rt == 2'h0) ? 62 : (rt == 2'h1) ? 15 : (rt == 2'h2) ? 7 : 6) * 4 * (2 + 9 * nb + (ty[1] ? 1 : 0));
    i_scm_slave_model.n_wr = 0;
    @(negedge i_ref_clk);
    {i_rate, i_type, i_wr_len, i_rd_len, i_addr, i_start} = {rt, ty, wl, rl, ad, 1'b1};
    @(negedge i_ref_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 20000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    cmp(16'(n > e - 6 && n < e + 6), 16'h0001);
    cmp({15'h0000, o_nack}, {15'h0000, nk});
  endtask
  task automatic t_write;
    load(3);
    xfer(`SCM_RATE_400K, `SCM_TYPE_WR, 5'h03, 5'h00, 7'h50, 4, 1'b0);
    chk_wr(3);
  endtask
  task automatic t_read;
    xfer(`SCM_RATE_1M, `SCM_TYPE_RD, 5'h00, 5'h14, 7'h50, 17, 1'b0);
    chk_rx(16);
  endtask
  task automatic t_wr_rd;
    load(2);
    xfer(`SCM_RATE_800K, `SCM_TYPE_WR_RD, 5'h02, 5'h03, 7'h50, 7, 1'b0);
    chk_wr(2);
    chk_rx(3);
  endtask
  task automatic t_rd_wr;
    load(16);
    xfer(`SCM_RATE_400K, `SCM_TYPE_RD_WR, 5'h10, 5'h01, 7'h50, 19, 1'b0);
    chk_rx(1);
    chk_wr(16);
  endtask
  task automatic t_nacks;
    xfer(`SCM_RATE_100K, `SCM_TYPE_WR, 5'h02, 5'h00, 7'h51, 1, 1'b1);
    chk_wr(0);
    nack_data = 1'b1;
    xfer(`SCM_RATE_1M, `SCM_TYPE_WR, 5'h04, 5'h00, 7'h50, 2, 1'b1);
    chk_wr(1);
    nack_data = 1'b0;
  endtask
  // reset, then every transfer type and rate back to back
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    t_write();
    t_read();
    t_wr_rd();
    t_rd_wr();
    t_nacks();
    end_sim();
  end
endmodule // testbench
